// ==== logic/dmm_consts.svh ====
// Constants for the drive monitor register bank.
// Assumes inclusion by bare name from every file that uses it.
`ifndef DMM_CONSTS_SVH
`define DMM_CONSTS_SVH
// Register numbers as the serial master sees them, counted from one.
`define DMM_REG_TORQUE 16'h0003
`define DMM_REG_RAMP 16'h0004
`define DMM_REG_STATUS 16'h0006
`define DMM_REG_FREQ 16'h0007
`define DMM_REG_CURRENT 16'h0008
`define DMM_REG_TORQUE_OUT 16'h0009
`define DMM_REG_POWER 16'h000a
`define DMM_REG_DIN 16'h000b
`define DMM_REG_AN1 16'h0014
`define DMM_REG_AN2 16'h0015
`define DMM_REG_PRE_RAMP 16'h0016
`define DMM_REG_DC_LINK 16'h0017
`define DMM_REG_HEATSINK 16'h0018
// Highest register that a multi-register write may touch.
`define DMM_REG_MULTI_MAX 16'h0004
// Function codes of the serial protocol.
`define DMM_FC_READ 8'h03
`define DMM_FC_WRITE_ONE 8'h06
`define DMM_FC_WRITE_MANY 8'h10
// Exception codes returned to the master.
`define DMM_EXC_FUNC 8'h01
`define DMM_EXC_ADDR 8'h02
`define DMM_EXC_VALUE 8'h03
// Largest ramp time, in hundredths of a second.
`define DMM_RAMP_MAX 16'hea60
// Ramp selection value that hands the ramp to the serial link.
`define DMM_RAMP_SEL_LINK 8'h01
// Reset values of the writable registers.
`define DMM_TORQUE_RST 16'h0000
`define DMM_RAMP_RST 16'h0000
// Status word bit positions.
`define DMM_ST_RUN 0
`define DMM_ST_TRIP 1
`define DMM_ST_INHIBIT 3
`define DMM_ST_MAINT 4
`define DMM_ST_STANDBY 5
`define DMM_ST_READY 6
`endif

// ==== logic/dmm_pkg.sv ====
// Types shared by the drive monitor register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dmm_pkg;
	// Live drive quantities, already scaled by the drive core.
	typedef struct packed {
		logic running;
		logic tripped;
		logic [7:0] faultCode;
		logic safeTorqueOffOpen;
		logic maintReached;
		logic standby;
		logic mainsOk;
		logic enableIn;
		logic [15:0] outFreq;
		logic [15:0] outCurrent;
		logic [15:0] outTorque;
		logic [15:0] outPower;
		logic [15:0] digIn;
		logic [15:0] analogOne;
		logic [15:0] analogTwo;
		logic [15:0] preRamp;
		logic [15:0] dcLink;
		logic [15:0] heatsink;
	} dmm_mon_s;
	// One register request from the frame layer.
	typedef struct packed {
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] data;
	} dmm_req_s;
	// One register answer to the frame layer.
	typedef struct packed {
		logic exc;
		logic [7:0] excCode;
		logic [15:0] data;
	} dmm_rsp_s;
endpackage
`default_nettype wire

// ==== logic/dmm_status_word.sv ====
// Builds the registered status and fault word from live drive flags.
// Assumes the flags are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.svh"
module dmm_status_word (
	input wire logic clk,
	input wire logic rst_n,
	input wire dmm_pkg::dmm_mon_s mon,
	output logic [15:0] statusWord_q
);
	logic [15:0] statusWord_d;

	// Unused bits stay zero so old masters see a stable pattern.
	always_comb begin
		statusWord_d = 16'h0000;
		statusWord_d[`DMM_ST_RUN] = mon.running;
		statusWord_d[`DMM_ST_TRIP] = mon.tripped;
		statusWord_d[`DMM_ST_INHIBIT] = mon.safeTorqueOffOpen;
		statusWord_d[`DMM_ST_MAINT] = mon.maintReached;
		statusWord_d[`DMM_ST_STANDBY] = mon.standby;
		statusWord_d[`DMM_ST_READY] = mon.mainsOk &&
			!mon.safeTorqueOffOpen && !mon.tripped && mon.enableIn;
		// A stale code is hidden once the trip clears.
		if (mon.tripped) begin
			statusWord_d[15:8] = mon.faultCode;
		end
	end

	// The word is sampled every cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			statusWord_q <= 16'h0000;
		end else begin
			statusWord_q <= statusWord_d;
		end
	end

	run_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		##1 statusWord_q[0] == $past(mon.running))
		else $error("Run bit does not follow the drive.");
	trip_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		##1 statusWord_q[1] == $past(mon.tripped))
		else $error("Trip bit does not follow the drive.");
	inhibit_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		##1 statusWord_q[3] == $past(mon.safeTorqueOffOpen))
		else $error("Inhibit bit does not follow the safe input.");
	maint_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		##1 statusWord_q[4] == $past(mon.maintReached))
		else $error("Maintenance bit is wrong.");
	standby_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		##1 statusWord_q[5] == $past(mon.standby))
		else $error("Standby bit is wrong.");
	ready_bit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		mon.tripped || mon.safeTorqueOffOpen || !mon.mainsOk ||
			!mon.enableIn
		|=> !statusWord_q[6])
		else $error("Ready bit set while not ready.");
	spare_bits_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!statusWord_q[2] && !statusWord_q[7])
		else $error("Spare status bits are not zero.");
	fault_byte_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		mon.tripped |=> statusWord_q[15:8] == $past(mon.faultCode))
		else $error("Fault code missing during a trip.");
endmodule // dmm_status_word
`default_nettype wire

// ==== logic/dmm_regs.sv ====
// Serial holding-register bank of a motor drive, registers 3 to 24.
// Assumes a frame layer hands over one register per request pulse and
// that all drive inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.svh"
module dmm_regs #(
	parameter int DIN_COUNT = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire dmm_pkg::dmm_req_s req,
	input wire dmm_pkg::dmm_mon_s mon,
	input wire logic [7:0] fieldbusRampSelect,
	input wire logic [7:0] primaryCommandSource,
	output logic rspValid_q,
	output dmm_pkg::dmm_rsp_s rsp_q,
	output logic [15:0] torqueSetpoint_q,
	output logic [15:0] rampTimeSetting_q,
	output logic rampOverride_q,
	output logic [15:0] appliedRamp_q
);
	logic [15:0] statusWord;
	logic [15:0] dinMask;
	dmm_pkg::dmm_rsp_s rsp_d;
	logic isWrite;
	logic writeOk;
	logic rampSelLink;

	// Any mapped register, read-only ones included.
	function automatic logic isMapped(input logic [15:0] a);
		isMapped = (a == `DMM_REG_TORQUE) || (a == `DMM_REG_RAMP) ||
			((a >= `DMM_REG_STATUS) && (a <= `DMM_REG_DIN)) ||
			((a >= `DMM_REG_AN1) && (a <= `DMM_REG_HEATSINK));
	endfunction

	// Only the two setpoint registers take writes.
	function automatic logic isWritable(input logic [15:0] a);
		isWritable = (a == `DMM_REG_TORQUE) || (a == `DMM_REG_RAMP);
	endfunction

	// Read multiplexer; unmapped numbers return zero.
	function automatic logic [15:0] readMux(input logic [15:0] a,
		input dmm_pkg::dmm_mon_s m, input logic [15:0] st,
		input logic [15:0] tq, input logic [15:0] rp,
		input logic [15:0] dm);
		readMux = 16'h0000;
		unique case (a)
			`DMM_REG_TORQUE: readMux = tq;
			`DMM_REG_RAMP: readMux = rp;
			`DMM_REG_STATUS: readMux = st;
			`DMM_REG_FREQ: readMux = m.outFreq;
			`DMM_REG_CURRENT: readMux = m.outCurrent;
			`DMM_REG_TORQUE_OUT: readMux = m.outTorque;
			`DMM_REG_POWER: readMux = m.outPower;
			`DMM_REG_DIN: readMux = m.digIn & dm;
			`DMM_REG_AN1: readMux = m.analogOne;
			`DMM_REG_AN2: readMux = m.analogTwo;
			`DMM_REG_PRE_RAMP: readMux = m.preRamp;
			`DMM_REG_DC_LINK: readMux = m.dcLink;
			`DMM_REG_HEATSINK: readMux = m.heatsink;
			default: readMux = 16'h0000;
		endcase
	endfunction

	// The status word is built and registered in its own module.
	dmm_status_word dmm_status_word_i (
		.clk(clk),
		.rst_n(rst_n),
		.mon(mon),
		.statusWord_q(statusWord)
	);

	// Inputs beyond the fitted count read as zero, never as noise.
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			dinMask[i] = (i < DIN_COUNT);
		end
	end

	assign isWrite = (req.func == `DMM_FC_WRITE_ONE) ||
		(req.func == `DMM_FC_WRITE_MANY);

	// Decide the answer for the current request.
	// Read-only and unmapped numbers both answer a write with an address
	// exception, so a write alone cannot tell them apart; that keeps the
	// decode small.
	always_comb begin
		rsp_d = '0;
		unique case (req.func)
			`DMM_FC_READ: begin
				if (!isMapped(req.addr)) begin
					rsp_d.exc = 1'b1;
					rsp_d.excCode = `DMM_EXC_ADDR;
				end else begin
					rsp_d.data = readMux(req.addr, mon, statusWord,
						torqueSetpoint_q, rampTimeSetting_q, dinMask);
				end
			end
			`DMM_FC_WRITE_ONE, `DMM_FC_WRITE_MANY: begin
				if ((req.func == `DMM_FC_WRITE_MANY) &&
					(req.addr > `DMM_REG_MULTI_MAX)) begin
					rsp_d.exc = 1'b1;
					rsp_d.excCode = `DMM_EXC_ADDR;
				end else if (!isWritable(req.addr)) begin
					rsp_d.exc = 1'b1;
					rsp_d.excCode = `DMM_EXC_ADDR;
				end else if ((req.addr == `DMM_REG_RAMP) &&
					(req.data > `DMM_RAMP_MAX)) begin
					rsp_d.exc = 1'b1;
					rsp_d.excCode = `DMM_EXC_VALUE;
				end else begin
					rsp_d.data = req.data;
				end
			end
			default: begin
				rsp_d.exc = 1'b1;
				rsp_d.excCode = `DMM_EXC_FUNC;
			end
		endcase
	end

	assign writeOk = reqValid && isWrite && !rsp_d.exc;

	// Answer one cycle after every request.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rspValid_q <= 1'b0;
			rsp_q <= '0;
		end else begin
			rspValid_q <= reqValid;
			if (reqValid) begin
				rsp_q <= rsp_d;
			end
		end
	end

	// Torque setpoint is stored as given; scaling is the master's job.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			torqueSetpoint_q <= `DMM_TORQUE_RST;
		end else if (writeOk && (req.addr == `DMM_REG_TORQUE)) begin
			torqueSetpoint_q <= req.data;
		end
	end

	// Out-of-range ramp writes were refused above, so storage stays legal.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rampTimeSetting_q <= `DMM_RAMP_RST;
		end else if (writeOk && (req.addr == `DMM_REG_RAMP)) begin
			rampTimeSetting_q <= req.data;
		end
	end

	// The command source setting is deliberately not consulted here.
	assign rampSelLink = (fieldbusRampSelect == `DMM_RAMP_SEL_LINK);

	// Hand the serial ramp to the ramp generator only when selected.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rampOverride_q <= 1'b0;
			appliedRamp_q <= 16'h0000;
		end else begin
			rampOverride_q <= rampSelLink;
			appliedRamp_q <= rampSelLink ? rampTimeSetting_q : 16'h0000;
		end
	end

	ramp_select_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(fieldbusRampSelect != `DMM_RAMP_SEL_LINK) |=>
			!rampOverride_q && (appliedRamp_q == 16'h0000))
		else $error("Serial ramp applied without selection.");

	ramp_follow_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		rampSelLink |=>
			rampOverride_q && (appliedRamp_q == $past(rampTimeSetting_q)))
		else $error("Selected serial ramp not applied.");

	ramp_range_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		rampTimeSetting_q <= `DMM_RAMP_MAX)
		else $error("Stored ramp time above range.");

	ramp_refuse_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && isWrite && (req.addr == `DMM_REG_RAMP) &&
			(req.data > `DMM_RAMP_MAX) |=>
			rspValid_q && rsp_q.exc &&
			(rsp_q.excCode == `DMM_EXC_VALUE) && $stable(rampTimeSetting_q))
		else $error("Out-of-range ramp write not refused.");

	status_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_STATUS) |=>
			rsp_q.data == $past(statusWord))
		else $error("Status read returns a wrong word.");

	freq_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_FREQ) |=>
			rsp_q.data == $past(mon.outFreq))
		else $error("Frequency read wrong.");

	current_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_CURRENT) |=>
			rsp_q.data == $past(mon.outCurrent))
		else $error("Current read wrong.");

	torque_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_TORQUE_OUT) |=>
			rsp_q.data == $past(mon.outTorque))
		else $error("Torque read wrong.");

	power_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_POWER) |=>
			rsp_q.data == $past(mon.outPower))
		else $error("Power read wrong.");

	din_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_DIN) |=>
			rsp_q.data[0] == $past(mon.digIn[0]))
		else $error("Digital input one not at bit zero.");

	analog_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_AN2) |=>
			rsp_q.data == $past(mon.analogTwo))
		else $error("Analog two read wrong.");

	preramp_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_PRE_RAMP) |=>
			rsp_q.data == $past(mon.preRamp))
		else $error("Pre-ramp setpoint read wrong.");

	dclink_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_DC_LINK) |=>
			rsp_q.data == $past(mon.dcLink))
		else $error("DC link voltage read wrong.");

	heat_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_HEATSINK) |=>
			rsp_q.data == $past(mon.heatsink))
		else $error("Heatsink read wrong.");

	func_code_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func != `DMM_FC_READ) && !isWrite |=>
			rspValid_q && rsp_q.exc && (rsp_q.excCode == `DMM_EXC_FUNC))
		else $error("Unknown function not refused.");

	multi_limit_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_WRITE_MANY) &&
			(req.addr > `DMM_REG_MULTI_MAX) |=>
			rsp_q.exc && (rsp_q.excCode == `DMM_EXC_ADDR))
		else $error("Multi write above register four accepted.");

	torque_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && isWrite && (req.addr == `DMM_REG_TORQUE) |=>
			!rsp_q.exc && (torqueSetpoint_q == $past(req.data)))
		else $error("Torque setpoint write lost.");

	ro_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && isWrite && isMapped(req.addr) &&
			!isWritable(req.addr) |=>
			rsp_q.exc && $stable(torqueSetpoint_q) &&
			$stable(rampTimeSetting_q))
		else $error("Read-only write not refused.");

	rsp_strobe_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid |=> rspValid_q)
		else $error("Request not answered in one cycle.");

	rsp_idle_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!reqValid |=> !rspValid_q)
		else $error("Answer strobe without a request.");

	unmapped_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) && !isMapped(req.addr) |=>
			rsp_q.exc && (rsp_q.excCode == `DMM_EXC_ADDR))
		else $error("Unmapped read not refused.");

	analog_one_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && (req.func == `DMM_FC_READ) &&
			(req.addr == `DMM_REG_AN1) |=>
			rsp_q.data == $past(mon.analogOne))
		else $error("Analog one read wrong.");

	ramp_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		reqValid && isWrite && (req.addr == `DMM_REG_RAMP) &&
			(req.data <= `DMM_RAMP_MAX) |=>
			!rsp_q.exc && (rampTimeSetting_q == $past(req.data)))
		else $error("Legal ramp write lost.");

	// The first edge after reset is skipped: the outputs still hold reset.
	source_ignored_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $changed(primaryCommandSource) &&
			$stable(fieldbusRampSelect) && $stable(rampTimeSetting_q) |=>
			$stable(rampOverride_q) && $stable(appliedRamp_q))
		else $error("Command source setting moved the ramp.");
endmodule // dmm_regs
`default_nettype wire

// ==== testbench/dmm_master.sv ====
// Frame-layer model that hands the register bank one register at a time.
// Assumes the bench calls send and samples the answer when it returns.
`timescale 1ns/1ps
`default_nettype none
module dmm_master (
	input wire logic clk,
	output logic reqValid,
	output dmm_pkg::dmm_req_s req
);
	// Nothing is requested until the bench asks.
	initial begin
		reqValid = 1'b0;
		req = '0;
	end

	// Raised 1 ns after an edge and taken at the next one, then released.
	// Register numbers are sent counted from one, as the bank expects.
	task automatic send(input logic [7:0] func, input logic [15:0] addr,
		input logic [15:0] data);
		@(posedge clk);
		#1;
		reqValid = 1'b1;
		req = '{func, addr, data};
		@(posedge clk);
		#1;
		reqValid = 1'b0;
		// Released fields flip so that no stale value can pass as valid.
		req = ~req;
	endtask
endmodule // dmm_master
`default_nettype wire

// ==== testbench/dmm_regs_bench.sv ====
// Self-checking bench for the drive register bank with a reference model.
// Assumes the frame-layer model dmm_master drives the register port.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_consts.svh"
module dmm_regs_bench;
	logic clk;
	logic rst_n;
	logic reqValid;
	dmm_pkg::dmm_req_s req;
	dmm_pkg::dmm_mon_s mon;
	logic [7:0] sel;
	logic [7:0] pcs;
	logic rspValid_q;
	dmm_pkg::dmm_rsp_s rsp_q;
	logic [15:0] torque_q;
	logic [15:0] ramp_q;
	logic override_q;
	logic [15:0] applied_q;
	int nErrors = 0;
	int nTests = 0;
	int seed = 32'h4111_1abb;
	int torqueM = 0;
	int rampM = 0;
	logic [7:0] dF [12] = '{8'h06, 8'h06, 8'h06, 8'h10, 8'h10, 8'h06,
		8'h03, 8'h03, 8'h03, 8'h04, 8'h10, 8'h03};
	logic [15:0] dA [12] = '{16'h0003, 16'h0004, 16'h0004, 16'h0004,
		16'h0006, 16'h0007, 16'h0006, 16'h000b, 16'h0005, 16'h0003,
		16'h0002, 16'h0003};
	logic [15:0] dD [12] = '{16'h07d0, 16'hea60, 16'hea61, 16'h0032,
		16'h0001, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0009,
		16'h0001, 16'h0000};
	logic [7:0] fTab [4] = '{8'h03, 8'h06, 8'h10, 8'h2b};

	// Eleven fitted inputs, so the unfitted top bits must read zero.
	dmm_regs #(.DIN_COUNT(11)) dmm_regs_i (.clk(clk), .rst_n(rst_n),
		.reqValid(reqValid), .req(req), .mon(mon),
		.fieldbusRampSelect(sel), .primaryCommandSource(pcs),
		.rspValid_q(rspValid_q), .rsp_q(rsp_q),
		.torqueSetpoint_q(torque_q), .rampTimeSetting_q(ramp_q),
		.rampOverride_q(override_q), .appliedRamp_q(applied_q));
	dmm_master dmm_master_i (.clk(clk), .reqValid(reqValid), .req(req));

	// 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic giveVerdict();
		$display("counts: %0d checks, %0d mismatches", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Status word as the drive flags say it should read.
	function automatic logic [15:0] statusOf(input dmm_pkg::dmm_mon_s m);
		logic ready;
		ready = m.mainsOk & ~m.safeTorqueOffOpen & ~m.tripped & m.enableIn;
		return {m.tripped ? m.faultCode : 8'h00, 1'b0, ready, m.standby,
			m.maintReached, m.safeTorqueOffOpen, 1'b0, m.tripped, m.running};
	endfunction

	// One request with fresh drive levels; the model predicts the answer.
	// Levels settle two edges ahead so the registered status has caught up.
	task automatic do_req(input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d);
		dmm_pkg::dmm_rsp_s e;
		logic [191:0] r;
		r = {$random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed), $random(seed)};
		mon = r[174:0];
		sel = {6'h00, 2'(r[191:190])};
		pcs = r[189:182];
		e = '0;
		if (f == `DMM_FC_READ) begin
			case (a)
				16'h0003: e.data = 16'(torqueM);
				16'h0004: e.data = 16'(rampM);
				16'h0006: e.data = statusOf(mon);
				16'h0007: e.data = mon.outFreq;
				16'h0008: e.data = mon.outCurrent;
				16'h0009: e.data = mon.outTorque;
				16'h000a: e.data = mon.outPower;
				16'h000b: e.data = mon.digIn & 16'h07ff;
				16'h0014: e.data = mon.analogOne;
				16'h0015: e.data = mon.analogTwo;
				16'h0016: e.data = mon.preRamp;
				16'h0017: e.data = mon.dcLink;
				16'h0018: e.data = mon.heatsink;
				default: e = {1'b1, `DMM_EXC_ADDR, 16'h0000};
			endcase
		end else if (f == `DMM_FC_WRITE_ONE || f == `DMM_FC_WRITE_MANY) begin
			if (a == 16'h0003) begin
				torqueM = d;
				e.data = d;
			end else if (a == 16'h0004 && d > 16'hea60) begin
				e = {1'b1, `DMM_EXC_VALUE, 16'h0000};
			end else if (a == 16'h0004) begin
				rampM = d;
				e.data = d;
			end else begin
				e = {1'b1, `DMM_EXC_ADDR, 16'h0000};
			end
		end else begin
			e = {1'b1, `DMM_EXC_FUNC, 16'h0000};
		end
		repeat (2) @(posedge clk);
		dmm_master_i.send(f, a, d);
		check("answer strobe", 16'(rspValid_q), 16'h0001);
		check("exception flag", 16'(rsp_q.exc), 16'(e.exc));
		if (e.exc) begin
			check("exception code", 16'(rsp_q.excCode), 16'(e.excCode));
		end
		check("answer data", rsp_q.data, e.data);
		check("torque register", torque_q, 16'(torqueM));
		check("ramp register", ramp_q, 16'(rampM));
		@(posedge clk);
		#1;
		check("strobe drop", 16'(rspValid_q), 16'h0000);
		check("ramp override", 16'(override_q), 16'(sel == 8'h01));
		check("applied ramp", applied_q,
			sel == 8'h01 ? 16'(rampM) : 16'h0000);
	endtask

	// Watchdog: the run needs about 1560 cycles, so 8000 means a hang.
	initial begin
		#200000;
		nErrors++;
		$display("watchdog expired");
		giveVerdict();
	end

	// Reset, then directed requests, then a random mix of every code.
	initial begin
		rst_n = 1'b0;
		mon = '0;
		sel = 8'h00;
		pcs = 8'h00;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check("reset strobe", 16'(rspValid_q), 16'h0000);
		check("reset torque", torque_q, 16'h0000);
		check("reset ramp", ramp_q, 16'h0000);
		check("reset applied", applied_q, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			do_req(dF[i], dA[i], dD[i]);
		end
		$display("test directed done");
		for (int i = 0; i < 300; i++) begin
			do_req(fTab[$random(seed) & 3], 16'($random(seed) & 31),
				i[1] ? 16'($random(seed)) : {15'h7530, i[0]});
		end
		$display("test random done");
		giveVerdict();
	end
endmodule // dmm_regs_bench
`default_nettype wire
